// ===== rtl/codec_ctrl_map.svh
// register map constants for the audio codec control bank
// assumes a 16-bit register port addressed by the printed byte offsets
`ifndef CODEC_CTRL_MAP_SVH
`define CODEC_CTRL_MAP_SVH

// register offsets
`define SPEAKER_OUTPUT_CTRL_OFS  16'h1282
`define REFERENCE_POWER_CTRL_OFS 16'h1284
`define SAMPLE_DATA_PORT_OFS     16'h1286
`define CONVERTER_CTRL_OFS       16'h1288
`define MIC_POWER_CTRL_OFS       16'h1290

// speaker output control fields
`define SPK_GAIN_HI              13
`define SPK_GAIN_LO              11
`define SPK_OBSOLETE_BIT         10
`define SPK_SE_EN_BIT            9
`define SPK_NEG_PD_BIT           5
`define SPK_NEG_MODE_HI          4
`define SPK_NEG_MODE_LO          3
`define SPK_POS_PD_BIT           2
`define SPK_POS_MODE_HI          1
`define SPK_POS_MODE_LO          0
`define SPK_RESET                16'h0524
`define SPK_WMASK                16'h3A3F

// reference power control fields
`define REF_AMP_BIAS_POWERDOWN_BIT          7
`define REF_BG_PD_BIT            6
`define REF_BUF_SEL_BIT          4
`define REF_POS_PD_BIT           0
`define REF_RESET                16'h0091
`define REF_WMASK                16'h00D1

// sample data port
`define SAMPLE_RESET             16'h0000

// converter control fields
`define CNV_SIDETONE_ON_BIT      15
`define CNV_SIDETONE_HI          14
`define CNV_SIDETONE_LO          12
`define CNV_CLK_GATE_BIT         10
`define CNV_INT_REF_PD_BIT       6
`define CNV_ADC_DITH_BIT         3
`define CNV_DAC_DITH_BIT         2
`define CNV_DAC_PD_BIT           1
`define CNV_ADC_PD_BIT           0
`define CNV_RESET                16'h3043
`define CNV_WMASK                16'hF44F

// microphone power control
`define MICROPHONE_AMP_POWERDOWN_BIT               2
`define MIC_RESET                16'h0004
`define MIC_WMASK                16'h0004

`endif

// ===== rtl/codec_ctrl_pkg.sv
// types shared by the codec control bank
// assumes the map header supplies offsets and field positions
package codec_ctrl_pkg;
   // output pin drive mode
   typedef enum logic [1:0]
   {
      mode_ground    = 2'h0,
      mode_reserved  = 2'h1,
      mode_diff      = 2'h2,
      mode_single    = 2'h3
   } out_mode_t;

   // register word
   typedef logic [15:0] reg_word_t;
endpackage

// ===== rtl/masked_reg.sv
// one 16-bit register with write mask and reset value
// assumes synchronous active-low reset and a one-cycle write strobe
`timescale 1ns/1ps
module masked_reg
   import codec_ctrl_pkg::*;
#(
   parameter reg_word_t RESET_VAL = 16'h0000,
   parameter reg_word_t WMASK     = 16'hFFFF
)
(
   input  wire logic      ref_clk,
   input  wire logic      rst_b,
   input  wire logic      wr_en,
   input  wire reg_word_t wr_data,
   output reg_word_t      value
);
   reg_word_t value_r;   // stored word
   reg_word_t value_nxt; // next word

   // only writable bits take new data, others keep reset value
   always_comb
   begin
      value_nxt = value_r;
      if (wr_en)
      begin
         value_nxt = (wr_data & WMASK) | (value_r & ~WMASK);
      end
   end

   // register stage
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         value_r <= RESET_VAL;
      end
      else
      begin
         value_r <= value_nxt;
      end
   end

   assign value = value_r;
endmodule

// ===== rtl/sample_path.sv
// sample holding registers between software and the converters
// assumes converter samples arrive with a one-cycle valid strobe
`timescale 1ns/1ps
`include "codec_ctrl_map.svh"
module sample_path
   import codec_ctrl_pkg::*;
(
   input  wire logic      ref_clk,
   input  wire logic      rst_b,
   input  wire logic      out_sel,
   input  wire logic      sw_wr,
   input  wire reg_word_t sw_data,
   input  wire logic      in_valid,
   input  wire reg_word_t in_sample,
   output reg_word_t      in_word,
   output reg_word_t      out_word
);
   reg_word_t in_r;    // input sample holding
   reg_word_t in_nxt;
   reg_word_t out_r;   // output sample holding
   reg_word_t out_nxt;

   // capture converter sample, load output only when selected
   always_comb
   begin
      in_nxt  = in_r;
      out_nxt = out_r;
      if (in_valid)
      begin
         in_nxt = in_sample;
      end
      if (sw_wr && out_sel)
      begin
         out_nxt = sw_data;
      end
   end

   // register stage
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         in_r  <= `SAMPLE_RESET;
         out_r <= `SAMPLE_RESET;
      end
      else
      begin
         in_r  <= in_nxt;
         out_r <= out_nxt;
      end
   end

   assign in_word  = in_r;
   assign out_word = out_r;
endmodule

// ===== rtl/codec_ctrl_regs.sv
// audio codec control register bank with analog control outputs
// assumes a plain register port, read data one cycle after the strobe
`timescale 1ns/1ps
`include "codec_ctrl_map.svh"
module codec_ctrl_regs
   import codec_ctrl_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       rst_b,
   input  wire logic [15:0] addr,
   input  wire reg_word_t  wr_data,
   input  wire logic       wr_stb,
   input  wire logic       rd_stb,
   output reg_word_t       rd_data,
   input  wire logic       adc_valid,
   input  wire reg_word_t  adc_sample,
   input  wire logic       dac_out_sel,
   output reg_word_t       dac_sample,
   output logic [2:0]      speaker_gain_sel,
   output logic            single_ended_conv_en,
   output logic            neg_out_amp_powerdown,
   output out_mode_t       neg_out_mode,
   output logic            pos_out_amp_powerdown,
   output out_mode_t       pos_out_mode,
   output logic            neg_speaker_output_hiz,
   output logic            pos_speaker_output_hiz,
   output logic            amp_bias_powerdown,
   output logic            bandgap_mirror_powerdown,
   output logic            buffer_resistor_sel,
   output logic            pos_ref_amp_powerdown,
   output logic            sidetone_on,
   output logic [2:0]      sidetone_atten,
   output logic            converter_clock_gate,
   output logic            internal_ref_powerdown,
   output logic            adc_dither_disable,
   output logic            dac_dither_disable,
   output logic            dac_powerdown,
   output logic            adc_powerdown,
   output logic            microphone_amp_powerdown,
   output logic            digital_off,
   output logic            mode_conflict
);
   // decoded write strobes
   logic      wr_spk;
   logic      wr_ref;
   logic      wr_data_port;
   logic      wr_cnv;
   logic      wr_mic;
   // register contents
   reg_word_t spk_q;
   reg_word_t ref_q;
   reg_word_t cnv_q;
   reg_word_t mic_q;
   reg_word_t in_word;
   // read pipeline
   reg_word_t rd_data_r;
   reg_word_t rd_data_nxt;
   // registered derived outputs
   logic      digital_off_r;
   logic      digital_off_nxt;
   logic      conflict_r;
   logic      conflict_nxt;

   // write decode, one strobe per register
   always_comb
   begin
      wr_spk       = wr_stb && (addr == `SPEAKER_OUTPUT_CTRL_OFS);
      wr_ref       = wr_stb && (addr == `REFERENCE_POWER_CTRL_OFS);
      wr_data_port = wr_stb && (addr == `SAMPLE_DATA_PORT_OFS);
      wr_cnv       = wr_stb && (addr == `CONVERTER_CTRL_OFS);
      wr_mic       = wr_stb && (addr == `MIC_POWER_CTRL_OFS);
   end

   masked_reg
   #(
      .RESET_VAL (`SPK_RESET),
      .WMASK     (`SPK_WMASK)
   )
   u_spk
   (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .wr_en   (wr_spk),
      .wr_data (wr_data),
      .value   (spk_q)
   );

   masked_reg
   #(
      .RESET_VAL (`REF_RESET),
      .WMASK     (`REF_WMASK)
   )
   u_ref
   (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .wr_en   (wr_ref),
      .wr_data (wr_data),
      .value   (ref_q)
   );

   masked_reg
   #(
      .RESET_VAL (`CNV_RESET),
      .WMASK     (`CNV_WMASK)
   )
   u_cnv
   (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .wr_en   (wr_cnv),
      .wr_data (wr_data),
      .value   (cnv_q)
   );

   masked_reg
   #(
      .RESET_VAL (`MIC_RESET),
      .WMASK     (`MIC_WMASK)
   )
   u_mic
   (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .wr_en   (wr_mic),
      .wr_data (wr_data),
      .value   (mic_q)
   );

   sample_path u_samples
   (
      .ref_clk   (ref_clk),
      .rst_b     (rst_b),
      .out_sel   (dac_out_sel),
      .sw_wr     (wr_data_port),
      .sw_data   (wr_data),
      .in_valid  (adc_valid),
      .in_sample (adc_sample),
      .in_word   (in_word),
      .out_word  (dac_sample)
   );

   // read mux, unmapped addresses return zero
   always_comb
   begin
      rd_data_nxt = 16'h0000;
      if (rd_stb)
      begin
         unique case (addr)
            `SPEAKER_OUTPUT_CTRL_OFS:  rd_data_nxt = spk_q;
            `REFERENCE_POWER_CTRL_OFS: rd_data_nxt = ref_q;
            `SAMPLE_DATA_PORT_OFS:     rd_data_nxt = in_word;
            `CONVERTER_CTRL_OFS:       rd_data_nxt = cnv_q;
            `MIC_POWER_CTRL_OFS:       rd_data_nxt = mic_q;
            default:                   rd_data_nxt = 16'h0000;
         endcase
      end
   end

   // derived status, computed from current register state
   always_comb
   begin
      digital_off_nxt = cnv_q[`CNV_CLK_GATE_BIT]
         | (cnv_q[`CNV_ADC_PD_BIT] & cnv_q[`CNV_DAC_PD_BIT]
            & mic_q[`MICROPHONE_AMP_POWERDOWN_BIT] & spk_q[`SPK_POS_PD_BIT]
            & spk_q[`SPK_NEG_PD_BIT]);
      conflict_nxt = ~spk_q[`SPK_SE_EN_BIT]
         & ((spk_q[`SPK_NEG_MODE_HI:`SPK_NEG_MODE_LO] == 2'h3)
            | (spk_q[`SPK_POS_MODE_HI:`SPK_POS_MODE_LO] == 2'h3));
   end

   // read data and status registers
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         rd_data_r     <= 16'h0000;
         digital_off_r <= 1'b1;
         conflict_r    <= 1'b0;
      end
      else
      begin
         rd_data_r     <= rd_data_nxt;
         digital_off_r <= digital_off_nxt;
         conflict_r    <= conflict_nxt;
      end
   end

   assign rd_data       = rd_data_r;
   assign digital_off   = digital_off_r;
   assign mode_conflict = conflict_r;

   // speaker field outputs
   // gain select out
   assign speaker_gain_sel      = spk_q[`SPK_GAIN_HI:`SPK_GAIN_LO];
   assign single_ended_conv_en  = spk_q[`SPK_SE_EN_BIT];
   assign neg_out_amp_powerdown = spk_q[`SPK_NEG_PD_BIT];
   assign neg_out_mode          =
      out_mode_t'(spk_q[`SPK_NEG_MODE_HI:`SPK_NEG_MODE_LO]);
   assign pos_out_amp_powerdown = spk_q[`SPK_POS_PD_BIT];
   assign pos_out_mode          =
      out_mode_t'(spk_q[`SPK_POS_MODE_HI:`SPK_POS_MODE_LO]);
   assign neg_speaker_output_hiz = spk_q[`SPK_NEG_PD_BIT]
      & (spk_q[`SPK_NEG_MODE_HI:`SPK_NEG_MODE_LO] == 2'h0);
   assign pos_speaker_output_hiz = spk_q[`SPK_POS_PD_BIT]
      & (spk_q[`SPK_POS_MODE_HI:`SPK_POS_MODE_LO] == 2'h0);

   // reference field outputs
   // bias powerdown out
   assign amp_bias_powerdown       = ref_q[`REF_AMP_BIAS_POWERDOWN_BIT];
   assign bandgap_mirror_powerdown = ref_q[`REF_BG_PD_BIT];
   assign buffer_resistor_sel      = ref_q[`REF_BUF_SEL_BIT];
   assign pos_ref_amp_powerdown    = ref_q[`REF_POS_PD_BIT];

   // converter and microphone field outputs
   // sidetone enable out
   assign sidetone_on            = cnv_q[`CNV_SIDETONE_ON_BIT];
   assign sidetone_atten         =
      cnv_q[`CNV_SIDETONE_HI:`CNV_SIDETONE_LO];
   assign converter_clock_gate   = cnv_q[`CNV_CLK_GATE_BIT];
   assign internal_ref_powerdown = cnv_q[`CNV_INT_REF_PD_BIT];
   assign adc_dither_disable     = cnv_q[`CNV_ADC_DITH_BIT];
   assign dac_dither_disable     = cnv_q[`CNV_DAC_DITH_BIT];
   assign dac_powerdown          = cnv_q[`CNV_DAC_PD_BIT];
   assign adc_powerdown          = cnv_q[`CNV_ADC_PD_BIT];
   assign microphone_amp_powerdown = mic_q[`MICROPHONE_AMP_POWERDOWN_BIT];
endmodule

// ===== verif/codec_ctrl_regs_monitor.sv
// checker for the codec control register bank
// assumes one clock domain and binding to codec_ctrl_regs
`timescale 1ns/1ps
module codec_ctrl_regs_monitor
   import codec_ctrl_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        rst_b,
   input wire logic [15:0] addr,
   input wire reg_word_t   wr_data,
   input wire logic        wr_stb,
   input wire logic        rd_stb,
   input wire reg_word_t   rd_data,
   input wire logic        dac_out_sel,
   input wire reg_word_t   dac_sample,
   input wire logic [2:0]  speaker_gain_sel,
   input wire logic [2:0]  sidetone_atten,
   input wire logic        single_ended_conv_en,
   input wire out_mode_t   neg_out_mode,
   input wire out_mode_t   pos_out_mode,
   input wire logic        neg_out_amp_powerdown,
   input wire logic        pos_out_amp_powerdown,
   input wire logic        converter_clock_gate,
   input wire logic        dac_powerdown,
   input wire logic        adc_powerdown,
   input wire logic        microphone_amp_powerdown,
   input wire logic        digital_off,
   input wire logic        mode_conflict
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   // decoded write strobes
   wire spk_wr = wr_stb && addr == 16'h1282;
   wire cnv_wr = wr_stb && addr == 16'h1288;
   wire dat_wr = wr_stb && addr == 16'h1286;
   // shut-off and mode conflict causes
   wire off_c = converter_clock_gate | (adc_powerdown & dac_powerdown &
                microphone_amp_powerdown & pos_out_amp_powerdown &
                neg_out_amp_powerdown);
   wire cf_c = !single_ended_conv_en &&
               (pos_out_mode == mode_single || neg_out_mode == mode_single);

   rd_idle_a: assert property (!rd_stb |=> rd_data == 16'h0000)
      else $error("read data not zero outside answer");
   gain_load_a: assert property (
      spk_wr |=> speaker_gain_sel == $past(wr_data[13:11]))
      else $error("speaker gain not loaded");
   gain_hold_a: assert property (
      !spk_wr |=> $stable(speaker_gain_sel))
      else $error("speaker gain changed without write");
   atten_load_a: assert property (
      cnv_wr |=> sidetone_atten == $past(wr_data[14:12]))
      else $error("sidetone attenuation not loaded");
   dac_load_a: assert property (
      dat_wr && dac_out_sel |=> dac_sample == $past(wr_data))
      else $error("output sample not loaded");
   dac_keep_a: assert property (
      dat_wr && !dac_out_sel |=> $stable(dac_sample))
      else $error("output sample loaded while deselected");
   digital_off_a: assert property (
      digital_off == $past(off_c))
      else $error("digital shut-off wrong");
   conflict_flag_a: assert property (
      mode_conflict == $past(cf_c))
      else $error("mode conflict flag wrong");

   // main scenarios
   cover property (dat_wr && dac_out_sel);
   cover property (digital_off ##1 !digital_off);
   cover property (!mode_conflict ##1 mode_conflict);
endmodule

bind codec_ctrl_regs codec_ctrl_regs_monitor mon
(
   .ref_clk(ref_clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data),
   .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
   .dac_out_sel(dac_out_sel), .dac_sample(dac_sample),
   .speaker_gain_sel(speaker_gain_sel), .sidetone_atten(sidetone_atten),
   .single_ended_conv_en(single_ended_conv_en),
   .neg_out_mode(neg_out_mode), .pos_out_mode(pos_out_mode),
   .neg_out_amp_powerdown(neg_out_amp_powerdown),
   .pos_out_amp_powerdown(pos_out_amp_powerdown),
   .converter_clock_gate(converter_clock_gate),
   .dac_powerdown(dac_powerdown), .adc_powerdown(adc_powerdown),
   .microphone_amp_powerdown(microphone_amp_powerdown),
   .digital_off(digital_off), .mode_conflict(mode_conflict)
);

// ===== verif/codec_ctrl_regs_bench.sv
// self-checking bench for the codec control register bank
// assumes the checker is bound from its own file
`timescale 1ns/1ps
module codec_ctrl_regs_bench
   import codec_ctrl_pkg::*;
;
   logic        ref_clk     = 1'b0;
   logic        rst_b       = 1'b0;
   logic [15:0] addr        = 16'h0000;
   reg_word_t   wr_data     = 16'h0000;
   logic        wr_stb      = 1'b0;
   logic        rd_stb      = 1'b0;
   logic        adc_valid   = 1'b0;
   reg_word_t   adc_sample  = 16'h0000;
   logic        dac_out_sel = 1'b0;
   reg_word_t   rd_data;
   reg_word_t   dac_sample;
   logic        neg_hiz, pos_hiz, dig_off, conflict;
   int          n_fail      = 0;
   int          cmp_count   = 0;
   // offsets, reset words and writable bits; last is unmapped
   reg_word_t   ofs [5]   = '{16'h1282, 16'h1284, 16'h1288, 16'h1290,
                              16'h128A};
   reg_word_t   rst_v [5] = '{16'h0524, 16'h0091, 16'h3043, 16'h0004,
                              16'h0000};
   reg_word_t   msk [5]   = '{16'h3A3F, 16'h00D1, 16'hF44F, 16'h0004,
                              16'h0000};

   // 200 MHz clock
   always #2.5 ref_clk = ~ref_clk;

   codec_ctrl_regs dut
   (
      .ref_clk(ref_clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
      .adc_valid(adc_valid), .adc_sample(adc_sample),
      .dac_out_sel(dac_out_sel), .dac_sample(dac_sample),
      .speaker_gain_sel(), .single_ended_conv_en(),
      .neg_out_amp_powerdown(), .neg_out_mode(),
      .pos_out_amp_powerdown(), .pos_out_mode(),
      .neg_speaker_output_hiz(neg_hiz), .pos_speaker_output_hiz(pos_hiz),
      .amp_bias_powerdown(), .bandgap_mirror_powerdown(),
      .buffer_resistor_sel(), .pos_ref_amp_powerdown(),
      .sidetone_on(), .sidetone_atten(), .converter_clock_gate(),
      .internal_ref_powerdown(), .adc_dither_disable(),
      .dac_dither_disable(), .dac_powerdown(), .adc_powerdown(),
      .microphone_amp_powerdown(), .digital_off(dig_off),
      .mode_conflict(conflict)
   );

   // compare and count
   task automatic chk(string nm, reg_word_t seen, reg_word_t exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask

   // step past an edge so its updates have landed
   task automatic tick();
      @(posedge ref_clk);
      #1;
   endtask

   // one-cycle write strobe
   task automatic wr(logic [15:0] a, reg_word_t d);
      @(posedge ref_clk);
      addr    <= a;
      wr_data <= d;
      wr_stb  <= 1'b1;
      @(posedge ref_clk);
      wr_stb  <= 1'b0;
      #1;
   endtask

   // one-cycle read strobe, data checked in the cycle after
   task automatic rd(logic [15:0] a, reg_word_t e, string nm);
      @(posedge ref_clk);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge ref_clk);
      rd_stb <= 1'b0;
      #1;
      chk(nm, rd_data, e);
   endtask

   task automatic report_and_stop();
      if (n_fail == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      repeat (10) @(posedge ref_clk);
      rst_b <= 1'b1;
      // reset words, then all ones, then all zeros
      for (int i = 0; i < 5; i++)
      begin
         rd(ofs[i], rst_v[i], "reset word");
         wr(ofs[i], 16'hFFFF);
         rd(ofs[i], rst_v[i] | msk[i], "ones word");
         wr(ofs[i], 16'h0000);
         rd(ofs[i], rst_v[i] & ~msk[i], "zero word");
      end
      chk("digital off", dig_off, 1'b0);
      // every gain and attenuation code
      for (int g = 0; g < 8; g++)
      begin
         wr(16'h1282, 16'(g) << 11);
         rd(16'h1282, 16'h0500 | 16'(g) << 11, "gain");
         wr(16'h1288, 16'(g) << 12);
         rd(16'h1288, 16'(g) << 12, "atten");
      end
      // every output mode with both amplifiers powered down
      for (int m = 0; m < 4; m++)
      begin
         wr(16'h1282, 16'h0024 | 16'(m) | 16'(m) << 3);
         tick();
         chk("neg hiz", neg_hiz, m == 0);
         chk("pos hiz", pos_hiz, m == 0);
         chk("conflict", conflict, m == 3);
      end
      wr(16'h1282, 16'h023F);
      tick();
      chk("conflict", conflict, 1'b0);
      // shut-off by all powerdowns, then by clock gate
      // software powers down unused blocks
      wr(16'h1288, 16'h0003);
      wr(16'h1290, 16'h0004);
      tick();
      chk("digital off", dig_off, 1'b1);
      wr(16'h1290, 16'h0000);
      tick();
      chk("digital off", dig_off, 1'b0);
      wr(16'h1288, 16'h0400);
      tick();
      chk("digital off", dig_off, 1'b1);
      // input sample capture, output sample only when selected
      @(posedge ref_clk);
      adc_sample <= 16'hA5C3;
      adc_valid  <= 1'b1;
      @(posedge ref_clk);
      adc_sample <= 16'h0F0F;
      adc_valid  <= 1'b0;
      rd(16'h1286, 16'hA5C3, "input sample");
      wr(16'h1286, 16'h5A3C);
      chk("output sample", dac_sample, 16'h0000);
      @(posedge ref_clk);
      dac_out_sel <= 1'b1;
      wr(16'h1286, 16'h5A3C);
      chk("output sample", dac_sample, 16'h5A3C);
      rd(16'h1286, 16'hA5C3, "input sample");
      // reset again in mid-run
      @(posedge ref_clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      #1;
      chk("output sample", dac_sample, 16'h0000);
      chk("digital off", dig_off, 1'b1);
      rd(16'h1288, 16'h3043, "reset word");
      report_and_stop();
   end

   // hang guard, far beyond the roughly 170 cycles needed
   initial
   begin
      repeat (3000) @(posedge ref_clk);
      n_fail++;
      report_and_stop();
   end
endmodule
